// >>> logic/pst_pkg.sv
// Package for the PWM shutdown and time base block.
// Assumes byte registers on a plain address/strobe port at 10 MHz.
package pst_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_SD_LEVELS = 4'h0;
  localparam logic [3:0] ADDR_SD_SOURCES = 4'h1;
  localparam logic [3:0] ADDR_TB_LOW = 4'h2;
  localparam logic [3:0] ADDR_TB_HIGH = 4'h3;
  localparam logic [3:0] ADDR_PH_LOW = 4'h4;
  localparam logic [3:0] ADDR_SD_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  localparam logic [7:0] LEVELS_FULL_MASK = 8'h3f;
  localparam logic [7:0] LEVELS_AB_MASK = 8'h03;
  localparam logic [7:0] SOURCES_MASK = 8'h9e;
  localparam int SRC_PIN_BIT = 7;
  localparam int SRC_CMP_LSB = 1;
  localparam int CTL_STATUS_BIT = 7;
  localparam int CTL_ENABLE_BIT = 6;
  localparam int CTL_RESTART_BIT = 5;
  localparam int CTL_OVERRIDE_BIT = 0;
  localparam logic [7:0] CONTROL_MASK = 8'he1;
  localparam int IRQ_SHUTDOWN_BIT = 0;
  localparam int IRQ_PHASE_BIT = 1;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h03;
  localparam logic [15:0] TB_RESET = 16'h0100;
  localparam logic [7:0] PH_LOW_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : pst_pkg

// >>> logic/pst_shutdown_if.sv
// Interface carrying shutdown controls and status between the modules.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pst_shutdown_if;
  logic [4:0] src_enable;
  logic [3:0] cmp_synced;
  logic pin_synced;
  logic enable;
  logic override;
  logic restart;
  logic sw_set;
  logic sw_clear;
  logic active;
  logic event_pulse;
  modport ctrl (output src_enable, cmp_synced, pin_synced, enable, override, restart, sw_set,
    sw_clear, input active, event_pulse);
  modport core (input src_enable, cmp_synced, pin_synced, enable, override, restart, sw_set,
    sw_clear, output active, event_pulse);
endinterface : pst_shutdown_if
`default_nettype wire

// >>> logic/pst_shutdown_core.sv
// Auto-shutdown state: source combining, latched status, restart.
// Assumes all inputs already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module pst_shutdown_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  pst_shutdown_if.core sd
);
  logic any_source;
  logic latched_reg;
  logic prev_source_reg;

  // OR of every enabled source, pin bit is the top enable bit.
  assign any_source = |(sd.src_enable & {sd.pin_synced, sd.cmp_synced});

  // Latched shutdown; software set acts as hardware, restart clears once sources drop.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      latched_reg <= 1'b0;
      prev_source_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      prev_source_reg <= any_source & sd.enable;
      if ((sd.enable && any_source) || sd.sw_set)
        latched_reg <= 1'b1;
      else if (sd.sw_clear || sd.restart)
        latched_reg <= 1'b0;
    end
  end

  // Override forces the levels but raises no event.
  assign sd.active = latched_reg | (sd.enable & sd.override);
  assign sd.event_pulse = sd.enable & any_source & ~prev_source_reg;
endmodule : pst_shutdown_core
`default_nettype wire

// >>> logic/pst_timebase_regs.sv
// Top of the PWM shutdown, time base and phase low byte block.
// Assumes a byte register port, phase high byte and PWM drive from elsewhere.
// Behaviour
// - In shutdown each output A..F drives its level bit; bit0 A, bit5 F.
// - On the two-output instance, level bits for C..F are not implemented.
// - Unused level bits 7-6 and source bits 6-5, 0 read as zero.
// - Source bit 7 makes the external shutdown pin cause shutdown.
// - Source bits 1..4 enable shutdown from comparators 1..4.
// - Sixteen-bit time base counter, read/write, low byte is bits 7-0.
// - Counter high byte is bits 15-8 and resets to 0x01.
// - Sixteen-bit phase value; low byte register is read/write, resets zero.
// - Enabled shutdown with a source asserted forces levels and sets flag.
// - Enabled override forces levels without raising the shutdown flag.
// - Phase match makes a rising edge event when counter equals phase.
// - Phase bits 15-8 come from the outside phase high byte.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pst_timebase_regs #(
  parameter bit TWO_OUTPUT_ONLY = 1'b0,
  parameter int OUTPUTS = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic external_shutdown_input,
  input wire logic [3:0] comparator_synced,
  input wire logic [7:0] phase_high_byte,
  input wire logic [OUTPUTS-1:0] pwm_drive,
  input wire logic phase_match_select,
  output logic [OUTPUTS-1:0] pwm_output,
  output logic [15:0] timebase_counter,
  output logic [15:0] phase_value,
  output logic shutdown_active,
  output logic rising_edge_event,
  output logic shutdown_irq_flag,
  output logic irq
);
  import pst_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pst_shutdown_if sd ();
  logic [7:0] levels_reg;
  logic [7:0] sources_reg;
  logic [7:0] control_reg;
  logic [7:0] ph_low_reg;
  logic [15:0] tb_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic [7:0] rdata_next;
  logic [7:0] level_mask;
  logic [15:0] phase_full;
  logic phase_hit;
  logic wr_ctl;

  // Masks away bits an instance or register does not implement.
  function automatic logic [7:0] keep(input logic [7:0] value, input logic [7:0] mask);
    keep = value & mask;
  endfunction : keep

  // Write strobe qualified by address.
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] target, input logic wr);
    hit = wr && (addr == target);
  endfunction : hit

  assign level_mask = TWO_OUTPUT_ONLY ? LEVELS_AB_MASK : LEVELS_FULL_MASK;
  assign phase_full = {phase_high_byte, ph_low_reg};
  assign phase_hit = phase_match_select && (tb_reg == phase_full);
  assign wr_ctl = hit(reg_addr, ADDR_SD_CONTROL, reg_write);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // Two flops on the external shutdown pin.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_meta_reg <= external_shutdown_input;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************************************
  // Shutdown core connection
  // ****************************************************************
  // Drive the shared controls into the shutdown core.
  assign sd.src_enable = {sources_reg[SRC_PIN_BIT], sources_reg[SRC_CMP_LSB +: 4]};
  assign sd.cmp_synced = comparator_synced;
  assign sd.pin_synced = pin_sync_reg;
  assign sd.enable = control_reg[CTL_ENABLE_BIT];
  assign sd.override = control_reg[CTL_OVERRIDE_BIT];
  assign sd.restart = control_reg[CTL_RESTART_BIT];
  assign sd.sw_set = wr_ctl && reg_wdata[CTL_STATUS_BIT];
  assign sd.sw_clear = wr_ctl && !reg_wdata[CTL_STATUS_BIT];

  pst_shutdown_core u_core (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .sd(sd)
  );

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Level, source, control and mask registers.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      levels_reg <= BYTE_ZERO;
      sources_reg <= BYTE_ZERO;
      control_reg <= BYTE_ZERO;
      irq_mask_reg <= BYTE_ZERO;
    end
    else if (clk_en)
    begin
      if (hit(reg_addr, ADDR_SD_LEVELS, reg_write))
        levels_reg <= keep(reg_wdata, level_mask);
      if (hit(reg_addr, ADDR_SD_SOURCES, reg_write))
        sources_reg <= keep(reg_wdata, SOURCES_MASK);
      if (wr_ctl)
        control_reg <= keep(reg_wdata, CONTROL_MASK);
      if (hit(reg_addr, ADDR_IRQ_MASK, reg_write))
        irq_mask_reg <= keep(reg_wdata, IRQ_MASK_BITS);
    end
  end

  // ****************************************************************
  // Time base and phase
  // ****************************************************************
  // Free-running counter with byte-wise software load.
  always_ff @(posedge clk)
  begin
    if (reset)
      tb_reg <= TB_RESET;
    else if (clk_en)
    begin
      if (hit(reg_addr, ADDR_TB_LOW, reg_write))
        tb_reg <= {tb_reg[15:8], reg_wdata};
      else if (hit(reg_addr, ADDR_TB_HIGH, reg_write))
        tb_reg <= {reg_wdata, tb_reg[7:0]};
      else
        tb_reg <= tb_reg + 16'h0001;
    end
  end

  // Phase low byte register.
  always_ff @(posedge clk)
  begin
    if (reset)
      ph_low_reg <= PH_LOW_RESET;
    else if (clk_en && hit(reg_addr, ADDR_PH_LOW, reg_write))
      ph_low_reg <= reg_wdata;
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // Sticky events; a read clears, but an event in that cycle wins.
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_status_reg <= BYTE_ZERO;
    else if (clk_en)
    begin
      if (reg_read && reg_addr == ADDR_IRQ_STATUS)
        irq_status_reg <= BYTE_ZERO;
      if (sd.event_pulse)
        irq_status_reg[IRQ_SHUTDOWN_BIT] <= 1'b1;
      if (phase_hit)
        irq_status_reg[IRQ_PHASE_BIT] <= 1'b1;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Selects the addressed register; unmapped addresses read zero.
  always_comb
  begin
    case (reg_addr)
      ADDR_SD_LEVELS: rdata_next = levels_reg;
      ADDR_SD_SOURCES: rdata_next = sources_reg;
      ADDR_TB_LOW: rdata_next = tb_reg[7:0];
      ADDR_TB_HIGH: rdata_next = tb_reg[15:8];
      ADDR_PH_LOW: rdata_next = ph_low_reg;
      ADDR_SD_CONTROL: rdata_next = {sd.active, control_reg[6:0]};
      ADDR_IRQ_STATUS: rdata_next = irq_status_reg;
      ADDR_IRQ_MASK: rdata_next = irq_mask_reg;
      default: rdata_next = BYTE_ZERO;
    endcase
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Every output comes from a flop; pins take shutdown levels when active.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= BYTE_ZERO;
      pwm_output <= '0;
      timebase_counter <= TB_RESET;
      phase_value <= 16'h0000;
      shutdown_active <= 1'b0;
      rising_edge_event <= 1'b0;
      shutdown_irq_flag <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rdata <= reg_read ? rdata_next : BYTE_ZERO;
      pwm_output <= sd.active ? levels_reg[OUTPUTS-1:0] : pwm_drive;
      timebase_counter <= tb_reg;
      phase_value <= phase_full;
      shutdown_active <= sd.active;
      rising_edge_event <= phase_hit;
      shutdown_irq_flag <= irq_status_reg[IRQ_SHUTDOWN_BIT];
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end
endmodule : pst_timebase_regs
`default_nettype wire

// >>> sim/pst_stage_model.sv
// Model of the comparators and the shutdown pin.
// Assumes trip requests from the bench on the block clock.
`timescale 1ns/1ps
`default_nettype none
module pst_stage_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [4:0] trip,
  output logic [3:0] comparator_synced,
  output logic external_shutdown_input
);
  logic [4:0] dly_reg = 5'h00;
  // A slow part answers one clock late.
  always @(posedge clk)
    dly_reg <= trip;
  assign {external_shutdown_input, comparator_synced} = slow ? dly_reg : trip;
endmodule : pst_stage_model
`default_nettype wire

// >>> sim/pst_timebase_regs_props.sv
// Port assertions for the shutdown and time base block.
// Assumes one clock and the map of pst_pkg.
`timescale 1ns/1ps
`default_nettype none
module pst_timebase_regs_props
  import pst_pkg::*;
#(
  parameter int OUTPUTS = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] phase_high_byte,
  input wire logic phase_match_select,
  input wire logic [OUTPUTS-1:0] pwm_output,
  input wire logic [15:0] timebase_counter,
  input wire logic [15:0] phase_value,
  input wire logic rising_edge_event
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // A quiet run of two cycles, and a low byte write followed by a run.
  sequence s_quiet; clk_en && !reg_write ##1 clk_en; endsequence
  sequence s_low_wr; clk_en && reg_write && reg_addr == ADDR_TB_LOW ##1 clk_en; endsequence
  // Each property ties an output to its cause with the exact latency.
  property p_rd_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_lvl_unused;
    $past(reg_read) && $past(reg_addr) == ADDR_SD_LEVELS |-> reg_rdata[7:6] == 2'b00;
  endproperty
  a_lvl_unused: assert property (p_lvl_unused) else $error("level bits 7-6 set");
  property p_src_unused;
    $past(reg_read) && $past(reg_addr) == ADDR_SD_SOURCES |-> (reg_rdata & ~SOURCES_MASK) == 0;
  endproperty
  a_src_unused: assert property (p_src_unused) else $error("source spare bit set");
  property p_tb_inc; s_quiet |=> timebase_counter == $past(timebase_counter) + 16'h1; endproperty
  a_tb_inc: assert property (p_tb_inc) else $error("counter step wrong");
  property p_tb_low; s_low_wr |=> timebase_counter[7:0] == $past(reg_wdata, 2); endproperty
  a_tb_low: assert property (p_tb_low) else $error("low byte write lost");
  property p_freeze; !clk_en |=> $stable(timebase_counter) && $stable(pwm_output); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_tb_reset; $fell(reset) |-> timebase_counter == 16'h0100; endproperty
  a_tb_reset: assert property (p_tb_reset) else $error("counter reset value");
  property p_ph_high;
    !$past(reset) && $past(clk_en) |-> phase_value[15:8] == $past(phase_high_byte);
  endproperty
  a_ph_high: assert property (p_ph_high) else $error("phase high byte");
  property p_edge_sel; rising_edge_event |-> $past(phase_match_select); endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("unselected match event");
endmodule : pst_timebase_regs_props
bind pst_timebase_regs pst_timebase_regs_props #(.OUTPUTS(OUTPUTS)) u_props (.clk(clk),
  .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .phase_high_byte(phase_high_byte), .phase_match_select(phase_match_select),
  .pwm_output(pwm_output), .timebase_counter(timebase_counter), .phase_value(phase_value),
  .rising_edge_event(rising_edge_event));
`default_nettype wire

// >>> sim/pst_timebase_regs_tb.sv
// Self-checking bench for the shutdown and time base block.
// Assumes the stage model feeds the comparator and pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pst_timebase_regs_tb;
  import pst_pkg::*;
  logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic slow = 1'b0, sel = 1'b0, seen, pin, active, ev, flag, irq;
  logic [3:0] reg_addr = 4'h0, cmp;
  logic [7:0] reg_wdata = 8'h00, ph_hi = 8'h00, rdata;
  logic [5:0] pwm;
  logic [15:0] cnt, ph;
  logic [4:0] trip = 5'h00;
  int err_total = 0, comparisons = 0, cycles = 0;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  pst_stage_model stage (.clk(clk), .slow(slow), .trip(trip), .comparator_synced(cmp),
    .external_shutdown_input(pin));
  pst_timebase_regs dut (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
    .external_shutdown_input(pin), .comparator_synced(cmp), .phase_high_byte(ph_hi),
    .pwm_drive(6'h15), .phase_match_select(sel), .pwm_output(pwm), .timebase_counter(cnt),
    .phase_value(ph), .shutdown_active(active), .rising_edge_event(ev),
    .shutdown_irq_flag(flag), .irq(irq));
  // Compares one value and counts it.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One register cycle; a read is compared with d.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk);
    {reg_write, reg_read} <= 2'b00;
    #1 if (!w) check(16'(rdata), 16'(d));
  endtask : bus
  // Prints the counts and the verdict.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // Stops a hung run.
  always @(posedge clk)
    if (++cycles == 5000)
    begin
      err_total++;
      test_done();
    end
  // Reset values, spare bits, an unmapped place and the phase bytes.
  task automatic t_regs;
    bus(0, ADDR_SD_LEVELS, 8'h00);
    bus(0, ADDR_SD_SOURCES, 8'h00);
    bus(0, ADDR_TB_HIGH, 8'h01);
    bus(0, ADDR_PH_LOW, 8'h00);
    bus(1, ADDR_SD_LEVELS, 8'hff);
    bus(0, ADDR_SD_LEVELS, 8'h3f);
    bus(1, ADDR_SD_SOURCES, 8'hff);
    bus(0, ADDR_SD_SOURCES, 8'h9e);
    bus(1, 4'hf, 8'h55);
    bus(0, 4'hf, 8'h00);
    bus(1, ADDR_PH_LOW, 8'ha5);
    ph_hi <= 8'h5a;
    bus(0, ADDR_PH_LOW, 8'ha5);
    check(ph, 16'h5aa5);
    $display("register test done");
  endtask : t_regs
  // Counter bytes, a frozen stretch and the wrap.
  task automatic t_counter;
    bus(1, ADDR_TB_HIGH, 8'h12);
    bus(1, ADDR_TB_LOW, 8'h34);
    @(posedge clk);
    #1 check(cnt, 16'h1234);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(cnt, 16'h1234);
    clk_en <= 1'b1;
    bus(0, ADDR_TB_HIGH, 8'h12);
    bus(1, ADDR_TB_HIGH, 8'hff);
    bus(1, ADDR_TB_LOW, 8'hff);
    repeat (2) @(posedge clk);
    #1 check(cnt, 16'h0000);
    $display("counter test done");
  endtask : t_counter
  // Each source, unselected then selected, with flag, irq and release.
  task automatic t_shutdown;
    logic [7:0] src [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
    bus(1, ADDR_SD_LEVELS, 8'h2a);
    bus(1, ADDR_IRQ_MASK, 8'h01);
    bus(1, ADDR_SD_CONTROL, 8'h40);
    for (int i = 0; i < 5; i++)
    begin
      slow <= (i == 4);
      bus(1, ADDR_SD_SOURCES, SOURCES_MASK & ~src[i]);
      trip <= 5'h01 << i;
      repeat (8) @(posedge clk);
      #1 check(16'(active), 16'h0000);
      bus(1, ADDR_SD_SOURCES, src[i]);
      repeat (12) if (active !== 1'b1) @(negedge clk);
      check(16'({flag, irq, pwm}), 16'h00ea);
      bus(0, ADDR_IRQ_STATUS, 8'h01);
      trip <= 5'h00;
      repeat (8) @(posedge clk);
      bus(1, ADDR_SD_CONTROL, 8'h40);
      repeat (3) @(posedge clk);
      #1 check(16'({irq, active, pwm}), 16'h0015);
    end
    bus(1, ADDR_SD_SOURCES, 8'h02);
    bus(1, ADDR_SD_CONTROL, 8'h60);
    trip <= 5'h01;
    repeat (4) @(posedge clk);
    #1 check(16'(active), 16'h0001);
    trip <= 5'h00;
    repeat (4) @(posedge clk);
    #1 check(16'(active), 16'h0000);
    bus(0, ADDR_IRQ_STATUS, 8'h01);
    bus(1, ADDR_SD_CONTROL, 8'h41);
    repeat (3) @(posedge clk);
    #1 check(16'({flag, pwm}), 16'h002a);
    bus(1, ADDR_SD_CONTROL, 8'h00);
    $display("shutdown test done");
  endtask : t_shutdown
  // Counter meets the phase value with the match source selected.
  task automatic t_phase;
    ph_hi <= 8'h20;
    sel <= 1'b1;
    bus(1, ADDR_PH_LOW, 8'h10);
    bus(1, ADDR_TB_HIGH, 8'h20);
    bus(1, ADDR_TB_LOW, 8'h00);
    seen = 1'b0;
    repeat (40) @(negedge clk) seen |= ev;
    check(16'(seen), 16'h0001);
    $display("phase test done");
  endtask : t_phase
  // Holds reset four cycles, then runs the tests.
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_counter();
    t_shutdown();
    t_phase();
    test_done();
  end
endmodule : pst_timebase_regs_tb
`default_nettype wire
